//--- pkg/acs_pkg.sv
// Constants, types and register map of the conversion sequencer.
// Assumes one 50 MHz system clock and a 32-bit AHB-Lite register bus.
package acs_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PINCFG_OFS = 8'h04;
    localparam logic [7:0] DIR_OFS = 8'h08;
    localparam logic [7:0] RESULT_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] IRQEN_OFS = 8'h14;
    localparam logic [7:0] PORT_OFS = 8'h18;
    localparam logic [7:0] PORTOUT_OFS = 8'h1C;

    // Control register fields
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_GO_BIT = 2;
    localparam int CTRL_CHAN_LSB = 3;
    localparam int CTRL_CLK_LSB = 6;
    // Status register fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_INV_LSB = 8;

    // Reset values
    localparam logic [7:0] PINCFG_RST = 8'hFF;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ****************************************************************
    // Conversion clock and timing
    // ****************************************************************
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_RC = 2'h3;
    localparam int DIV2_TOSC = 2;
    localparam int DIV8_TOSC = 8;
    localparam int DIV32_TOSC = 32;
    localparam logic [4:0] DIV2_LAST = 5'(DIV2_TOSC - 1);
    localparam logic [4:0] DIV8_LAST = 5'(DIV8_TOSC - 1);
    localparam logic [4:0] DIV32_LAST = 5'(DIV32_TOSC - 1);

    localparam real CLK_PERIOD_NS = 20.0;
    localparam real TAD_MIN_US = 1.6;
    localparam int TAD_MIN_CYC =
        int'($ceil(TAD_MIN_US * 1000.0 / CLK_PERIOD_NS));
    localparam logic [8:0] TAD_MIN_CYC9 = 9'(TAD_MIN_CYC);

    localparam int TOSC_PER_INSTR = 4;
    localparam logic [1:0] INSTR_LAST = 2'(TOSC_PER_INSTR - 1);
    localparam logic [1:0] POST_WAIT_LAST = 2'h1;
    localparam logic [3:0] LAST_BIT_PHASE = 4'h8;
    localparam logic [7:0] MSB_TRIAL = 8'h80;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_OFF, ST_ACQ, ST_START_DLY, ST_CONV, ST_WAIT2, ST_PWRDN
    } acs_state_e;

    typedef struct packed {
        logic [7:0] dacCode;
        logic [2:0] chanSel;
        logic holdConnect;
        logic converterPowered;
    } acs_afe_s;

    typedef struct packed {
        acs_state_e st;
        logic convOn;
        logic goDone;
        logic [2:0] chan;
        logic [1:0] clkSel;
        logic [7:0] pinCfg;
        logic [7:0] dir;
        logic [7:0] portOut;
        logic [7:0] result;
        logic [7:0] resInv;
        logic doneFlag;
        logic irqEn;
        logic [7:0] sar;
        logic [7:0] trial;
        logic [7:0] invMask;
        logic invSeen;
        logic [3:0] phase;
        logic [4:0] divCnt;
        logic [7:0] tadLen;
        logic [2:0] rcSync;
        logic [1:0] dlyCnt;
        logic [1:0] waitCnt;
        logic wake;
        acs_afe_s afe;
        logic wrPend;
        logic [7:0] wrAddr;
        logic rdPend;
        logic [7:0] rdAddr;
        logic hreadyout;
        logic [31:0] hrdata;
    } acs_state_s;

endpackage : acs_pkg

//--- src/acs_sequencer.sv
// Conversion sequencer for an 8-bit successive-approximation converter.
// Assumes a comparator input synchronous to ref_clk and a free-running
// RC oscillator level on rcClkIn.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Converter front end
    input wire logic compHigh,
    input wire logic rcClkIn,
    output acs_afe_s afeOut,
    // Port pins
    input wire logic [7:0] padIn,
    output logic [7:0] padOut,
    output logic [7:0] padOeN,
    // Processor power state
    input wire logic sleepMode,
    output logic wakeUp
);

    // ****************************************************************
    // State
    // ****************************************************************
    acs_state_s s_r;
    acs_state_s s_nxt;

    logic rcTick;
    logic osTick;
    logic tadTick;
    logic rcSel;
    logic [4:0] divLast;
    logic shortTad;
    logic badBit;
    logic compIn;
    logic busy;
    logic take;
    logic ctrlWr;
    logic [31:0] wd;
    logic [7:0] sarNew;
    logic done;

    function automatic logic [31:0] readMux(input acs_state_s s,
                                            input logic [7:0] addr,
                                            input logic [7:0] pins);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (addr)
            CTRL_OFS:
            begin
                v[CTRL_ON_BIT] = s.convOn;
                v[CTRL_GO_BIT] = s.goDone;
                v[CTRL_CHAN_LSB +: 3] = s.chan;
                v[CTRL_CLK_LSB +: 2] = s.clkSel;
            end
            PINCFG_OFS: v[7:0] = s.pinCfg;
            DIR_OFS: v[7:0] = s.dir;
            RESULT_OFS: v[7:0] = s.result;
            STATUS_OFS:
            begin
                v[STAT_DONE_BIT] = s.doneFlag;
                v[STAT_INV_LSB +: 8] = s.resInv;
            end
            IRQEN_OFS: v[0] = s.irqEn;
            PORT_OFS: v[7:0] = pins & ~s.pinCfg;
            PORTOUT_OFS: v[7:0] = s.portOut;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : readMux

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wake = 1'b0;
        wd = hwdata;
        done = 1'b0;

        // RC edges pass two flops before anything looks at them
        s_nxt.rcSync = {s_r.rcSync[1:0], rcClkIn};
        rcTick = s_r.rcSync[1] & ~s_r.rcSync[2];

        rcSel = (s_r.clkSel == CLK_RC);
        unique case (s_r.clkSel)
            CLK_DIV2: divLast = DIV2_LAST;
            CLK_DIV8: divLast = DIV8_LAST;
            CLK_DIV32: divLast = DIV32_LAST;
            default: divLast = DIV2_LAST;
        endcase
        // Compare against the current selection every cycle, so a switch
        // among divided clocks takes effect in the running period
        osTick = (s_r.divCnt >= divLast);
        s_nxt.divCnt = osTick ? 5'h00 : s_r.divCnt + 5'h01;
        tadTick = rcSel ? rcTick : osTick;

        // Bit period length in ref_clk cycles, saturating
        shortTad = ({1'b0, s_r.tadLen} + 9'h001) < TAD_MIN_CYC9;
        if (tadTick)
            s_nxt.tadLen = 8'h00;
        else if (s_r.tadLen != 8'hFF)
            s_nxt.tadLen = s_r.tadLen + 8'h01;
        badBit = s_r.invSeen | shortTad;

        // Output-direction pin feeds its own driven level
        compIn = s_r.dir[s_r.chan] ? compHigh
                                   : s_r.portOut[s_r.chan];
        sarNew = compIn ? (s_r.sar | s_r.trial) : s_r.sar;
        busy = (s_r.st == ST_START_DLY) || (s_r.st == ST_CONV);

        // ************************************************************
        // Bus: address phase, then data phase
        // ************************************************************
        take = hsel && htrans[1] && hready;
        s_nxt.wrPend = take && hwrite;
        if (take)
        begin
            s_nxt.wrAddr = haddr[7:0];
            s_nxt.rdAddr = haddr[7:0];
        end
        s_nxt.rdPend = take && !hwrite;
        s_nxt.hreadyout = !(take && !hwrite);
        if (s_r.rdPend)
            s_nxt.hrdata = readMux(s_r, s_r.rdAddr, padIn);

        ctrlWr = s_r.wrPend && (s_r.wrAddr == CTRL_OFS);
        if (s_r.wrPend)
        begin
            unique case (s_r.wrAddr)
                CTRL_OFS:
                begin
                    s_nxt.convOn = wd[CTRL_ON_BIT];
                    s_nxt.chan = wd[CTRL_CHAN_LSB +: 3];
                    s_nxt.clkSel = wd[CTRL_CLK_LSB +: 2];
                end
                PINCFG_OFS: s_nxt.pinCfg = wd[7:0];
                DIR_OFS: s_nxt.dir = wd[7:0];
                RESULT_OFS: s_nxt.result = wd[7:0];
                STATUS_OFS:
                    if (wd[STAT_DONE_BIT])
                        s_nxt.doneFlag = 1'b0;
                IRQEN_OFS: s_nxt.irqEn = wd[0];
                PORTOUT_OFS: s_nxt.portOut = wd[7:0];
                default:
                begin
                end
            endcase
        end
        // Go is only taken while idle and powered; a go written
        // together with power-on is accepted, software must not rely
        if (ctrlWr && !busy)
            s_nxt.goDone = wd[CTRL_GO_BIT] && wd[CTRL_ON_BIT];

        // ************************************************************
        // Sequencer
        // ************************************************************
        unique case (s_r.st)
            ST_OFF:
            begin
                s_nxt.afe.holdConnect = 1'b0;
                if (s_nxt.convOn)
                    s_nxt.st = ST_ACQ;
            end
            ST_ACQ:
            begin
                // Acquisition runs until go, whatever the resolution
                s_nxt.afe.holdConnect = 1'b1;
                if (s_r.goDone)
                begin
                    s_nxt.afe.holdConnect = 1'b0;
                    s_nxt.st = rcSel ? ST_START_DLY : ST_CONV;
                    s_nxt.dlyCnt = 2'h0;
                    s_nxt.phase = 4'h0;
                    s_nxt.sar = 8'h00;
                    s_nxt.trial = 8'h00;
                    s_nxt.invMask = 8'h00;
                    s_nxt.invSeen = 1'b0;
                    s_nxt.divCnt = 5'h00;
                    s_nxt.tadLen = 8'h00;
                end
            end
            ST_START_DLY:
            begin
                s_nxt.dlyCnt = s_r.dlyCnt + 2'h1;
                if (s_r.dlyCnt == INSTR_LAST)
                begin
                    s_nxt.st = ST_CONV;
                    s_nxt.tadLen = 8'h00;
                end
            end
            ST_CONV:
            begin
                if (tadTick)
                begin
                    if (s_r.phase == 4'h0)
                        s_nxt.trial = MSB_TRIAL;
                    else
                    begin
                        s_nxt.sar = sarNew;
                        s_nxt.trial = s_r.trial >> 1;
                        s_nxt.invSeen = badBit;
                        if (badBit)
                            s_nxt.invMask = s_r.invMask | s_r.trial;
                    end
                    s_nxt.phase = s_r.phase + 4'h1;
                    if (s_r.phase == LAST_BIT_PHASE)
                        done = 1'b1;
                end
                if (done)
                begin
                    // Result, go and flag move together; the flag set
                    // wins over a clear in the same cycle
                    s_nxt.result = sarNew;
                    s_nxt.resInv = badBit ? (s_r.invMask | s_r.trial)
                                          : s_r.invMask;
                    s_nxt.goDone = 1'b0;
                    s_nxt.doneFlag = 1'b1;
                    s_nxt.trial = 8'h00;
                    s_nxt.waitCnt = 2'h0;
                    s_nxt.st = ST_WAIT2;
                    if (sleepMode && s_r.irqEn)
                        s_nxt.wake = 1'b1;
                    else if (sleepMode)
                        s_nxt.st = ST_PWRDN;
                end
            end
            ST_WAIT2:
            begin
                s_nxt.afe.holdConnect = 1'b0;
                if (tadTick)
                begin
                    s_nxt.waitCnt = s_r.waitCnt + 2'h1;
                    if (s_r.waitCnt == POST_WAIT_LAST)
                        s_nxt.st = ST_ACQ;
                end
            end
            ST_PWRDN:
            begin
                s_nxt.afe.holdConnect = 1'b0;
                if (!sleepMode)
                begin
                    s_nxt.waitCnt = 2'h0;
                    s_nxt.divCnt = 5'h00;
                    s_nxt.st = ST_WAIT2;
                end
            end
        endcase

        // Software abort: a completing conversion still wins
        if (busy && ctrlWr && !wd[CTRL_GO_BIT] && !done)
        begin
            s_nxt.goDone = 1'b0;
            s_nxt.sar = 8'h00;
            s_nxt.trial = 8'h00;
            s_nxt.waitCnt = 2'h0;
            // Restart the divider so the wait spans two whole periods
            s_nxt.divCnt = 5'h00;
            s_nxt.st = ST_WAIT2;
        end
        // Sleep kills a conversion on a divided clock
        if (busy && sleepMode && !rcSel && !done)
        begin
            s_nxt.goDone = 1'b0;
            s_nxt.trial = 8'h00;
            s_nxt.st = ST_PWRDN;
        end
        // Converter off overrides state and go; a completing result and flag still land
        if (!s_nxt.convOn)
        begin
            s_nxt.goDone = 1'b0;
            s_nxt.trial = 8'h00;
            s_nxt.afe.holdConnect = 1'b0;
            s_nxt.st = ST_OFF;
        end

        // Power drops while powered down, the on bit stays set
        s_nxt.afe.converterPowered = s_nxt.convOn &&
            (s_nxt.st != ST_PWRDN);
        s_nxt.afe.dacCode = s_nxt.sar | s_nxt.trial;
        s_nxt.afe.chanSel = s_nxt.chan;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.st <= ST_OFF;
            s_r.pinCfg <= PINCFG_RST;
            s_r.dir <= DIR_RST;
            s_r.result <= BYTE_RST;
            s_r.hreadyout <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign hreadyout = s_r.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = s_r.hrdata;
    assign afeOut = s_r.afe;
    assign padOut = s_r.portOut;
    assign padOeN = s_r.dir;
    assign wakeUp = s_r.wake;

endmodule : acs_sequencer

`default_nettype wire

//--- sim/acs_analog_model.sv
// Analog pins and holding capacitor in front of the converter.
// Assumes afeOut and pad outputs change only after ref_clk edges.
`timescale 1ns/1ps
`default_nettype none

module acs_analog_model
    import acs_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Pin levels chosen by the bench
    input wire logic [7:0][7:0] level,
    // Device side
    input wire acs_afe_s afeOut,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOeN,
    output logic compHigh,
    output logic [7:0] padIn
);
    // ****************
    // Pins and sample-and-hold
    // ****************
    logic [7:0] held;
    logic [7:0] pinLvl;
    logic flip = 1'b0;

    // Driven pin sits at its own rail
    assign pinLvl = padOeN[afeOut.chanSel] ? level[afeOut.chanSel]
        : {8{padOut[afeOut.chanSel]}};

    always_ff @(posedge ref_clk)
    begin
        flip <= !flip;
        if (afeOut.holdConnect)
            held <= pinLvl;
    end

    // Held level sits half a step above its code; unpowered output wanders
    assign compHigh = afeOut.converterPowered ? held >= afeOut.dacCode : flip;

    always_comb
    begin
        for (int i = 0; i < 8; i++)
            padIn[i] = padOeN[i] ? level[i][7] : padOut[i];
    end
endmodule : acs_analog_model

`default_nettype wire

//--- sim/acs_sequencer_assertions.sv
// Port checker for the conversion sequencer, bound to its top module.
// Assumes hready is tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer_assertions
    import acs_pkg::*;
(
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Front end and power
    input wire acs_afe_s afeOut,
    input wire logic [7:0] padOeN,
    input wire logic sleepMode,
    input wire logic wakeUp
);
    // ****************
    // Helper logic
    // ****************
    logic ctlWr_r;
    logic [1:0] clkSel_r;
    logic [7:0] prevDac_r;
    logic [5:0] gap_r;
    logic [5:0] expGap;
    logic clkChg_r;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctlWr_r <= 1'b0;
            clkSel_r <= CLK_DIV2;
            prevDac_r <= 8'h00;
            gap_r <= 6'h00;
            clkChg_r <= 1'b0;
        end
        else
        begin
            if (hready)
                ctlWr_r <= hsel && htrans[1] && hwrite
                    && haddr[7:0] == CTRL_OFS;
            if (ctlWr_r && hready)
                clkSel_r <= hwdata[7:6];
            prevDac_r <= afeOut.dacCode;
            // Period cut short by a clock switch is not measured
            if (ctlWr_r && hready && hwdata[7:6] != clkSel_r)
                clkChg_r <= 1'b1;
            else if (afeOut.dacCode != prevDac_r)
                clkChg_r <= 1'b0;
            // Saturates so idle time never aliases a bit period
            gap_r <= (afeOut.dacCode != prevDac_r) ? 6'h00
                : (gap_r == 6'h3F) ? gap_r : gap_r + 6'h01;
        end
    end

    assign expGap = (clkSel_r == CLK_DIV2) ? 6'h01
        : (clkSel_r == CLK_DIV8) ? 6'h07 : 6'h1F;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_hold_off;
        (!afeOut.holdConnect)[*4];
    endsequence

    property p_reset_out;
        $rose(rst_n) |-> afeOut == '0 && padOeN == DIR_RST && !wakeUp;
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_rd_wait;
        $fell(hreadyout) |-> $past(hsel && htrans[1] && !hwrite) ##1 hreadyout;
    endproperty
    property p_hold_gap;
        $fell(afeOut.holdConnect) && afeOut.converterPowered |-> s_hold_off;
    endproperty
    property p_msb_first;
        $fell(afeOut.holdConnect) && afeOut.converterPowered
            |-> ##[1:600] afeOut.dacCode == MSB_TRIAL;
    endproperty
    property p_bit_period;
        afeOut.dacCode != prevDac_r && prevDac_r != 8'h00
            && afeOut.dacCode != 8'h00 && afeOut.dacCode != MSB_TRIAL
            && clkSel_r != CLK_RC && !clkChg_r |-> gap_r == expGap;
    endproperty
    property p_wake_sleep;
        wakeUp |-> sleepMode;
    endproperty
    property p_wake_pulse;
        wakeUp |=> !wakeUp;
    endproperty

    a_reset_out: assert property (p_reset_out)
        else $error("outputs wrong after reset");
    a_okay: assert property (p_okay)
        else $error("bus response not okay");
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state wrong");
    a_hold_gap: assert property (p_hold_gap)
        else $error("capacitor reconnected too soon");
    a_msb_first: assert property (p_msb_first)
        else $error("first trial missing");
    a_bit_period: assert property (p_bit_period)
        else $error("bit period wrong");
    a_wake_sleep: assert property (p_wake_sleep)
        else $error("wake pulse while awake");
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake pulse too long");
endmodule : acs_sequencer_assertions

bind acs_sequencer acs_sequencer_assertions u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .afeOut(afeOut),
    .padOeN(padOeN), .sleepMode(sleepMode), .wakeUp(wakeUp)
);

`default_nettype wire

//--- sim/adc_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer over AHB-Lite.
// Assumes the analog model of acs_analog_model on the pin side.
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer_test
    import acs_pkg::*;
;
    // ****************
    // Bench signals and instances
    // ****************
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic sleepMode = 1'b0;
    logic rcClkIn = 1'b0;
    logic hready, hreadyout, hresp, compHigh, wakeUp;
    logic [31:0] hrdata, rd;
    logic [7:0] padIn, padOut, padOeN;
    acs_afe_s afeOut;
    logic [7:0][7:0] level;
    int errCount = 0;
    int nTests = 0;
    int k;
    logic [1:0] cs [4] = '{CLK_DIV2, CLK_DIV8, CLK_DIV32, CLK_RC};
    logic [2:0] chs [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
    logic [7:0] res [4] = '{8'h3C, 8'hFF, 8'h00, 8'hA7};
    logic [7:0] inv [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h00};
    logic [7:0] ofs [7] = '{CTRL_OFS, PINCFG_OFS, DIR_OFS, RESULT_OFS,
        STATUS_OFS, IRQEN_OFS, PORTOUT_OFS};
    logic [7:0] rv [7] = '{8'h00, PINCFG_RST, DIR_RST, 8'h00, 8'h00,
        8'h00, 8'h00};

    assign hready = hreadyout;
    always #10 ref_clk = ~ref_clk;
    // Odd half period keeps the RC clock drifting against ref_clk
    always #2003 rcClkIn = ~rcClkIn;

    acs_sequencer DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .compHigh(compHigh), .rcClkIn(rcClkIn),
        .afeOut(afeOut), .padIn(padIn), .padOut(padOut),
        .padOeN(padOeN), .sleepMode(sleepMode), .wakeUp(wakeUp)
    );
    acs_analog_model u_pins (
        .ref_clk(ref_clk), .level(level), .afeOut(afeOut),
        .padOut(padOut), .padOeN(padOeN), .compHigh(compHigh),
        .padIn(padIn)
    );

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        nTests++;
        if (g !== e)
        begin
            errCount++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // Entered just after a clock edge; returns at the closing edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wreg

    task automatic rchk(input string n, input logic [7:0] a,
        input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        chk(n, e, rd);
    endtask : rchk

    function automatic logic [31:0] ctl(input logic [1:0] c,
        input logic [2:0] ch, input logic go);
        return {24'h000000, c, ch, go, 2'h1};
    endfunction : ctl

    // Turns on, waits until acquisition runs, lets it settle, then starts
    task automatic start(input logic [1:0] c, input logic [2:0] ch);
        wreg(CTRL_OFS, ctl(c, ch, 1'b0));
        // A pending reconnect wait must end before settling time counts
        k = 0;
        while (afeOut.holdConnect !== 1'b1 && k < 1000)
        begin
            @(posedge ref_clk);
            k++;
        end
        chk("acquiring", 32'h1, {31'h0, k < 1000});
        repeat (100) @(posedge ref_clk);
        wreg(CTRL_OFS, ctl(c, ch, 1'b1));
    endtask : start

    task automatic reportAndStop();
        $display("checks %0d errors %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : reportAndStop

    initial
    begin
        #1000000;
        errCount++;
        reportAndStop();
    end

    initial
    begin
        level = '0;
        level[1] = 8'h3C;
        level[5] = 8'hA7;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rchk("reset value", ofs[i], {24'h000000, rv[i]});
        wreg(8'h20, 32'hFFFFFFFF);
        rchk("unmapped", 8'h20, 32'h00000000);
        wreg(PINCFG_OFS, 32'h000000DF);
        wreg(DIR_OFS, 32'h000000F3);
        wreg(PORTOUT_OFS, 32'h00000004);
        @(posedge ref_clk);
        chk("pad enables", 32'h000000F3, {24'h000000, padOeN});
        chk("pad outputs", 32'h00000004, {24'h000000, padOut});
        rchk("port", PORT_OFS, 32'h00000020);
        // ****************
        // Abort keeps the old result
        // ****************
        wreg(RESULT_OFS, 32'h0000005A);
        start(CLK_DIV32, 3'h1);
        repeat (60) @(posedge ref_clk);
        wreg(CTRL_OFS, ctl(CLK_DIV32, 3'h1, 1'b0));
        k = 0;
        while (afeOut.holdConnect !== 1'b1 && k < 200)
        begin
            @(posedge ref_clk);
            k++;
        end
        chk("reacquire", 32'h1, {31'h0, k >= 62 && k <= 72});
        rchk("ctrl", CTRL_OFS, ctl(CLK_DIV32, 3'h1, 1'b0));
        rchk("kept result", RESULT_OFS, 32'h0000005A);
        rchk("no flag", STATUS_OFS, 32'h00000000);
        // ****************
        // One conversion per clock choice
        // ****************
        for (int i = 0; i < 4; i++)
        begin
            start(cs[i], chs[i]);
            if (i == 2)
            begin
                // Five periods cover the first period and four bits
                repeat (160) @(posedge ref_clk);
                wreg(CTRL_OFS, ctl(CLK_DIV2, chs[i], 1'b1));
            end
            k = 0;
            do
            begin
                xfer(1'b0, CTRL_OFS, 32'h00000000);
                k++;
            end
            while (rd[CTRL_GO_BIT] !== 1'b0 && k < 2000);
            chk("go cleared", 32'h0, {31'h0, rd[CTRL_GO_BIT]});
            rchk("result", RESULT_OFS, {24'h0, res[i]});
            rchk("status", STATUS_OFS, {16'h0, inv[i], 8'h01});
            wreg(STATUS_OFS, 32'h00000001);
            rchk("cleared", STATUS_OFS, {16'h0, inv[i], 8'h00});
        end
        // ****************
        // Sleep
        // ****************
        start(CLK_DIV8, 3'h1);
        repeat (20) @(posedge ref_clk);
        sleepMode <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("powered", 32'h0, {31'h0, afeOut.converterPowered});
        rchk("ctrl", CTRL_OFS, ctl(CLK_DIV8, 3'h1, 1'b0));
        rchk("no flag", STATUS_OFS, 32'h00000000);
        sleepMode <= 1'b0;
        for (int j = 1; j >= 0; j--)
        begin
            wreg(IRQEN_OFS, 32'(j));
            start(CLK_RC, j ? 3'h1 : 3'h5);
            sleepMode <= 1'b1;
            k = 0;
            do
            begin
                @(posedge ref_clk);
                k++;
            end
            while (wakeUp !== 1'b1 && afeOut.converterPowered !== 1'b0
                && k < 3000);
            chk("sleep end", 32'h1, {31'h0, k < 3000});
            sleepMode <= 1'b0;
            chk("wake", 32'(j), {31'h0, wakeUp});
            rchk("ctrl", CTRL_OFS, ctl(CLK_RC, j ? 3'h1 : 3'h5, 1'b0));
            rchk("result", RESULT_OFS, j ? 32'h3C : 32'hA7);
        end
        reportAndStop();
    end
endmodule : adc_conversion_sequencer_test

`default_nettype wire
